// [rtl/sstel_pkg.sv]
// Constants, types and timing figures for the subsector trailer and error logic
package sstel_pkg;

  // Core clock period in ns
  localparam int CORE_CLK_NS        = 20;

  // Subsector layout, counted in serial bits
  localparam int BITS_PER_WORD      = 16;
  localparam int WORDS_PER_SUB      = 16;
  localparam logic [3:0] BIT_LAST   = 4'hf;
  localparam logic [3:0] WORD_LAST  = 4'hf;
  localparam logic [3:0] BIT_ZERO   = 4'h0;
  localparam logic [3:0] READ_PRELOAD = 4'hf;

  // Restart pulse and hang timeout, in ns and in core cycles
  localparam int RESTART_PULSE_NS   = 200;
  localparam int HANG_TIMEOUT_NS    = 300;
  localparam int RESTART_CYC        = (RESTART_PULSE_NS + CORE_CLK_NS - 1) / CORE_CLK_NS;
  localparam int HANG_CYC           = HANG_TIMEOUT_NS / CORE_CLK_NS;

  // Error status field positions and reset value
  localparam int ERR_DISC_FAIL_BIT  = 10;
  localparam int ERR_WPROT_BIT      = 11;
  localparam int ERR_TIMING_BIT     = 12;
  localparam int ERR_ILL_ADDR_BIT   = 13;
  localparam int ERR_READ_BIT       = 14;
  localparam int ERR_ANY_BIT        = 15;
  localparam logic [15:0] ERR_STATUS_RESET = 16'h0000;

  // Error status word, one field per condition
  typedef struct packed {
    logic       any_error;
    logic       read_error;
    logic       illegal_address;
    logic       transfer_timing;
    logic       write_protect;
    logic       disc_failure;
    logic [9:0] reserved;
  } sstel_status_s;

  // Signals coming from the disc unit on pins
  typedef struct packed {
    logic drive_ready_input;
    logic protected_address_input;
    logic subsector_sync_pulse;
    logic sequence_match;
  } sstel_disc_in_s;

  // Link-side trailer sequencer states
  typedef enum logic [3:0] {
    SEQ_IDLE   = 4'b0001,
    SEQ_DATA   = 4'b0010,
    SEQ_CHECK  = 4'b0100,
    SEQ_PARITY = 4'b1000
  } sstel_seq_e;

endpackage : sstel_pkg

// [rtl/sstel_trailer.sv]
// Subsector trailer sequencing, sector restart, hang watchdog and error status
// Summary of operation
// - Write: last-word indicator after 240 bits
// - Write: check cycle set on 256th bit
// - Check cycle sends code word, blocks data
// - After sixteen check bits, enter parity cycle
// - Parity cycle sends one parity bit
// - Parity end fires strobe, drops write line
// - Strobe gives 200 ns pulse driving write go
// - Repeat until end and buffer empty, stop
// - Read: preload fifteen, last word after 241
// - Read strobe drops read line, pulses go
// - Repeat read until end of read
// - Errors in status bits ten to fourteen
// - Bit fifteen set when any error set
// - Drive ready loss checked only during transfers
// - Drive ready loss sets disc failure
// - Initiation starts the hang timer
// - Sector go retriggers timer; timeout is failure
// - Failure ends operation, drops busy, interrupts
// - Protected address at write subsector start flags error
`timescale 1ns/10ps
module sstel_trailer
  import sstel_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC,
  parameter int HANG_CYCLES    = HANG_CYC
) (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic           disc_bit_clk,
  input  wire logic           start_write,
  input  wire logic           start_read,
  input  wire logic           end_indicator,
  input  wire logic           buffer_empty,
  input  wire logic           end_of_read,
  input  wire logic           interrupt_disable_flag,
  input  wire logic           transfer_timing_error,
  input  wire logic           illegal_address_error,
  input  wire logic           read_error,
  input  sstel_disc_in_s      disc_in,
  input  wire logic           data_bit,
  input  wire logic [15:0]    check_word,
  input  wire logic           parity_bit,
  output logic                write_line,
  output logic                read_line,
  output logic                write_sector_go,
  output logic                read_sector_go,
  output logic                end_of_subsector_strobe,
  output logic                selected_busy,
  output logic                done,
  output logic                interrupt_request,
  output sstel_status_s       error_status,
  output logic                last_word_indicator,
  output logic                check_word_cycle_flag,
  output logic                parity_cycle_flag,
  output logic                disc_write_data,
  output logic                data_suppress
);

  localparam int RCW = $clog2(RESTART_CYCLES + 1);
  localparam int HCW = $clog2(HANG_CYCLES + 1);
  localparam logic [RCW-1:0] RESTART_LOAD = RCW'(RESTART_CYCLES);
  localparam logic [HCW-1:0] HANG_LOAD    = HCW'(HANG_CYCLES);

  // ---------------------------------------------------------------- core side
  logic           write_operation_flag_r;
  logic           read_operation_flag_r;
  logic           write_active_flag_r;
  logic           read_active_flag_r;
  logic           done_r;
  logic           irq_r;
  logic           strobe_r;
  logic [RCW-1:0] restart_cnt_r;
  logic [HCW-1:0] hang_timer_r;
  logic           disc_failure_flag_r;
  logic           write_protect_error_flag_r;
  logic           start_tgl_r;
  logic           read_mode_r;
  sstel_status_s  status_r;
  sstel_disc_in_s disc_meta_r;
  sstel_disc_in_s disc_sync_r;
  sstel_disc_in_s disc_prev_r;
  logic [2:0]     end_tgl_sync_r;

  // Link-side registers
  sstel_seq_e     seq_r;
  logic [3:0]     bit_cnt_r;
  logic [3:0]     word_cnt_r;
  logic           first_clk_r;
  logic           lw_r;
  logic           end_tgl_r;
  logic           seen_tgl_r;
  logic [1:0]     start_sync_r;
  logic [1:0]     mode_sync_r;

  // Decoded core conditions
  wire            init_pulse      = start_write | start_read;
  wire            op_running      = write_operation_flag_r | read_operation_flag_r;
  wire            xfer_active     = write_active_flag_r | read_active_flag_r;
  wire            restart_active  = restart_cnt_r != '0;
  wire            sub_sync_rise   = disc_sync_r.subsector_sync_pulse &
                                    ~disc_prev_r.subsector_sync_pulse;
  wire            ready_fall      = ~disc_sync_r.drive_ready_input &
                                    disc_prev_r.drive_ready_input;
  wire            end_event       = end_tgl_sync_r[1] ^ end_tgl_sync_r[2];
  wire            sub_start       = sub_sync_rise & op_running & ~xfer_active &
                                    ~restart_active & disc_sync_r.sequence_match;
  wire            wp_hit          = sub_start & write_operation_flag_r &
                                    disc_sync_r.protected_address_input;
  wire            fail_ready      = ready_fall & xfer_active &
                                    disc_sync_r.sequence_match;
  wire            fail_hang       = op_running & ~xfer_active & ~restart_active &
                                    (hang_timer_r == '0);
  wire            fail_set        = (fail_ready | fail_hang) & ~disc_failure_flag_r;
  wire            write_finished  = end_event & write_operation_flag_r &
                                    end_indicator & buffer_empty;
  wire            read_finished   = end_event & read_operation_flag_r &
                                    end_of_read;
  wire            error_end       = fail_set | wp_hit;
  wire            op_end          = op_running & (write_finished | read_finished | error_end);

  // Pin synchroniser and edge history; stage one feeds stage two only
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disc_meta_r <= '0;
      disc_sync_r <= '0;
      disc_prev_r <= '0;
    end else begin
      disc_meta_r <= disc_in;
      disc_sync_r <= disc_meta_r;
      disc_prev_r <= disc_sync_r;
    end
  end

  // End-of-trailer toggle from the link domain, plus one stage for the edge
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      end_tgl_sync_r <= '0;
    end else begin
      end_tgl_sync_r <= {end_tgl_sync_r[1:0], end_tgl_r};
    end
  end

  // Operation flags; an ending or failure clears them
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_operation_flag_r <= 1'b0;
      read_operation_flag_r  <= 1'b0;
    end else if (init_pulse) begin
      write_operation_flag_r <= start_write;
      read_operation_flag_r  <= start_read & ~start_write;
    end else if (op_end) begin
      write_operation_flag_r <= 1'b0;
      read_operation_flag_r  <= 1'b0;
    end
  end

  // Transfer lines to the disc: set at subsector start, cleared by the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      write_active_flag_r <= 1'b0;
      read_active_flag_r  <= 1'b0;
    end else if (init_pulse | end_event | error_end) begin
      write_active_flag_r <= 1'b0;
      read_active_flag_r  <= 1'b0;
    end else if (sub_start) begin
      write_active_flag_r <= write_operation_flag_r;
      read_active_flag_r  <= read_operation_flag_r;
    end
  end

  // Start toggle and mode handed to the link domain at each subsector start without a protect hit
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      start_tgl_r <= 1'b0;
      read_mode_r <= 1'b0;
    end else if (sub_start & ~wp_hit) begin
      start_tgl_r <= ~start_tgl_r;
      read_mode_r <= read_operation_flag_r;
    end
  end

  // Strobe and restart pulse; the pulse also opens each operation
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      strobe_r      <= 1'b0;
      restart_cnt_r <= '0;
    end else begin
      strobe_r <= end_event & op_running;
      if (init_pulse | (end_event & op_running & ~op_end)) begin
        restart_cnt_r <= RESTART_LOAD;
      end else if (restart_active) begin
        restart_cnt_r <= restart_cnt_r - 1'b1;
      end
    end
  end

  // Hang watchdog, reloaded by initiation and every sector-go pulse
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hang_timer_r <= HANG_LOAD;
    end else if (init_pulse | restart_active | xfer_active) begin
      hang_timer_r <= HANG_LOAD;
    end else if (op_running & (hang_timer_r != '0)) begin
      hang_timer_r <= hang_timer_r - 1'b1;
    end
  end

  // Error flags: cleared at initiation, a coincident set wins
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      disc_failure_flag_r        <= 1'b0;
      write_protect_error_flag_r <= 1'b0;
    end else begin
      disc_failure_flag_r        <= (disc_failure_flag_r & ~init_pulse) | fail_set;
      write_protect_error_flag_r <= (write_protect_error_flag_r & ~init_pulse) | wp_hit;
    end
  end

  // Done, busy and interrupt request
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      done_r <= 1'b0;
      irq_r  <= 1'b0;
    end else begin
      done_r <= (done_r & ~init_pulse) | op_end;
      irq_r  <= op_end & ~interrupt_disable_flag;
    end
  end

  // Status word assembly
  sstel_status_s status_nxt;
  always_comb begin
    status_nxt                 = sstel_status_s'(ERR_STATUS_RESET);
    status_nxt.disc_failure    = disc_failure_flag_r;
    status_nxt.write_protect   = write_protect_error_flag_r;
    status_nxt.transfer_timing = transfer_timing_error;
    status_nxt.illegal_address = illegal_address_error;
    status_nxt.read_error      = read_error;
    status_nxt.any_error       = disc_failure_flag_r | write_protect_error_flag_r |
                                 transfer_timing_error | illegal_address_error |
                                 read_error;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      status_r <= sstel_status_s'(ERR_STATUS_RESET);
    end else begin
      status_r <= status_nxt;
    end
  end

  // Core outputs
  assign write_line              = write_active_flag_r;
  assign read_line               = read_active_flag_r;
  assign write_sector_go         = restart_active & write_operation_flag_r;
  assign read_sector_go          = restart_active & read_operation_flag_r;
  assign end_of_subsector_strobe = strobe_r;
  assign selected_busy           = op_running;
  assign done                    = done_r;
  assign interrupt_request       = irq_r;
  assign error_status            = status_r;

  // ---------------------------------------------------------------- link side
  // Start toggle and mode brought over on the disc bit clock
  always_ff @(posedge disc_bit_clk or posedge rst) begin
    if (rst) begin
      start_sync_r <= '0;
      mode_sync_r  <= '0;
    end else begin
      start_sync_r <= {start_sync_r[0], start_tgl_r};
      mode_sync_r  <= {mode_sync_r[0], read_mode_r};
    end
  end

  wire new_sub   = start_sync_r[1] ^ seen_tgl_r;
  wire bit_wrap  = bit_cnt_r == BIT_LAST;
  wire word_last = word_cnt_r == WORD_LAST;

  // Trailer sequencer next-state decode
  sstel_seq_e seq_nxt;
  logic [3:0] bit_cnt_nxt;
  logic [3:0] word_cnt_nxt;
  logic       first_clk_nxt;
  logic       end_tgl_nxt;
  always_comb begin
    seq_nxt       = seq_r;
    bit_cnt_nxt   = bit_cnt_r;
    word_cnt_nxt  = word_cnt_r;
    first_clk_nxt = 1'b0;
    end_tgl_nxt   = end_tgl_r;
    case (seq_r)
      SEQ_IDLE: begin
        seq_nxt = SEQ_IDLE;
      end
      SEQ_DATA: begin
        bit_cnt_nxt = bit_cnt_r + 1'b1;
        if (bit_wrap & ~first_clk_r) begin
          if (word_last) begin
            seq_nxt      = SEQ_CHECK;
            word_cnt_nxt = '0;
          end else begin
            word_cnt_nxt = word_cnt_r + 1'b1;
          end
        end
      end
      SEQ_CHECK: begin
        bit_cnt_nxt = bit_cnt_r + 1'b1;
        if (bit_wrap) begin
          seq_nxt = SEQ_PARITY;
        end
      end
      SEQ_PARITY: begin
        seq_nxt     = SEQ_IDLE;
        end_tgl_nxt = ~end_tgl_r;
      end
      default: begin
        seq_nxt = SEQ_IDLE;
      end
    endcase
    // New subsector restarts from any state; drops a cut frame
    if (new_sub) begin
      seq_nxt       = SEQ_DATA;
      bit_cnt_nxt   = mode_sync_r[1] ? READ_PRELOAD : BIT_ZERO;
      word_cnt_nxt  = '0;
      first_clk_nxt = mode_sync_r[1];
    end
  end

  // Sequencer state and counters on the bit clock
  always_ff @(posedge disc_bit_clk or posedge rst) begin
    if (rst) begin
      seq_r       <= SEQ_IDLE;
      bit_cnt_r   <= '0;
      word_cnt_r  <= '0;
      first_clk_r <= 1'b0;
      end_tgl_r   <= 1'b0;
      seen_tgl_r  <= 1'b0;
    end else begin
      seq_r       <= seq_nxt;
      bit_cnt_r   <= bit_cnt_nxt;
      word_cnt_r  <= word_cnt_nxt;
      first_clk_r <= first_clk_nxt;
      end_tgl_r   <= end_tgl_nxt;
      seen_tgl_r  <= start_sync_r[1];
    end
  end

  // Last-word indicator held in a flop
  always_ff @(posedge disc_bit_clk or posedge rst) begin
    if (rst) begin
      lw_r <= 1'b0;
    end else begin
      lw_r <= (seq_nxt == SEQ_DATA) & (word_cnt_nxt == WORD_LAST);
    end
  end

  // Serial source select: code word, then parity, else data
  wire in_check  = seq_r == SEQ_CHECK;
  wire in_parity = seq_r == SEQ_PARITY;
  assign disc_write_data       = in_check  ? check_word[BIT_LAST - bit_cnt_r] :
                                 in_parity ? parity_bit : data_bit;
  assign data_suppress         = in_check | in_parity;
  assign check_word_cycle_flag = in_check;
  assign parity_cycle_flag     = in_parity;
  assign last_word_indicator   = lw_r;

endmodule : sstel_trailer

// [tb/sstel_trailer_checker.sv]
// Assertion checker for the subsector trailer and error logic
`timescale 1ns/10ps
module sstel_trailer_checker
  import sstel_pkg::*;
#(
  parameter int RESTART_CYCLES = RESTART_CYC,
  parameter int HANG_CYCLES    = HANG_CYC
) (
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        disc_bit_clk,
  input wire logic [15:0] check_word,
  input wire logic        write_line,
  input wire logic        read_line,
  input wire logic        write_sector_go,
  input wire logic        read_sector_go,
  input wire logic        end_of_subsector_strobe,
  input wire logic        selected_busy,
  input wire logic        done,
  input sstel_status_s    error_status,
  input wire logic        last_word_indicator,
  input wire logic        check_word_cycle_flag,
  input wire logic        parity_cycle_flag,
  input wire logic        disc_write_data,
  input wire logic        data_suppress
);
  logic [3:0] chk_idx_r;
  logic [7:0] go_cnt_r;
  logic [7:0] hang_cnt_r;
  wire logic  go_any;
  wire logic  idle_wait;

  // Busy with neither transfer nor restart pulse: the hang window
  assign go_any    = write_sector_go || read_sector_go;
  assign idle_wait = selected_busy && !write_line && !read_line && !go_any;

  // Position within the check word
  always_ff @(posedge disc_bit_clk or posedge rst) begin
    if (rst) chk_idx_r <= 4'h0;
    else chk_idx_r <= check_word_cycle_flag ? chk_idx_r + 4'h1 : 4'h0;
  end

  // Length of the restart pulse and of the hang window
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      go_cnt_r   <= 8'h00;
      hang_cnt_r <= 8'h00;
    end else begin
      go_cnt_r   <= go_any ? go_cnt_r + 8'h01 : 8'h00;
      hang_cnt_r <= idle_wait ? hang_cnt_r + 8'h01 : 8'h00;
    end
  end

  a_last_word_len: assert property (@(posedge disc_bit_clk) disable iff (rst)
    $rose(last_word_indicator) |-> last_word_indicator[*8] ##1 last_word_indicator[*8]
    ##1 (!last_word_indicator && check_word_cycle_flag)) else $error("last word span wrong");
  a_check_len: assert property (@(posedge disc_bit_clk) disable iff (rst)
    $rose(check_word_cycle_flag) |-> check_word_cycle_flag[*8] ##1 check_word_cycle_flag[*8]
    ##1 (parity_cycle_flag && !check_word_cycle_flag)) else $error("check span wrong");
  a_parity_once: assert property (@(posedge disc_bit_clk) disable iff (rst)
    $rose(parity_cycle_flag) |=> !parity_cycle_flag) else $error("parity span wrong");
  a_data_blocked: assert property (@(posedge disc_bit_clk) disable iff (rst)
    (check_word_cycle_flag || parity_cycle_flag) |-> data_suppress) else $error("data not blocked");
  a_check_bits: assert property (@(posedge disc_bit_clk) disable iff (rst)
    (check_word_cycle_flag && write_line) |-> disc_write_data == check_word[4'hf - chk_idx_r])
    else $error("check bit wrong");
  a_go_width: assert property (@(posedge core_clk) disable iff (rst)
    $fell(go_any) |-> go_cnt_r == RESTART_CYCLES) else $error("restart pulse width wrong");
  a_strobe_drops: assert property (@(posedge core_clk) disable iff (rst)
    end_of_subsector_strobe |-> !write_line && !read_line) else $error("line held at strobe");
  a_any_error: assert property (@(posedge core_clk) disable iff (rst)
    error_status[15] == (|error_status[14:10])) else $error("summary bit wrong");
  a_fail_ends: assert property (@(posedge core_clk) disable iff (rst)
    $rose(error_status.disc_failure) |-> ##[0:4] (done && !selected_busy))
    else $error("failure did not end operation");
  a_hang_bound: assert property (@(posedge core_clk) disable iff (rst)
    idle_wait |-> hang_cnt_r <= HANG_CYCLES + 3) else $error("hang not detected");
endmodule : sstel_trailer_checker

bind sstel_trailer sstel_trailer_checker #(
  .RESTART_CYCLES(RESTART_CYCLES), .HANG_CYCLES(HANG_CYCLES)
) u_checker (.core_clk(core_clk), .rst(rst), .disc_bit_clk(disc_bit_clk),
  .check_word(check_word), .write_line(write_line), .read_line(read_line),
  .write_sector_go(write_sector_go), .read_sector_go(read_sector_go),
  .end_of_subsector_strobe(end_of_subsector_strobe), .selected_busy(selected_busy),
  .done(done), .error_status(error_status), .last_word_indicator(last_word_indicator),
  .check_word_cycle_flag(check_word_cycle_flag), .parity_cycle_flag(parity_cycle_flag),
  .disc_write_data(disc_write_data), .data_suppress(data_suppress));

// [tb/sstel_disc_model.sv]
// Behavioural disc unit: bit clock, subsector sync, ready and protect pins
`timescale 1ns/10ps
module sstel_disc_model
  import sstel_pkg::*;
(
  input wire logic    write_line,
  input wire logic    read_line,
  input wire logic    write_sector_go,
  input wire logic    read_sector_go,
  input wire logic    disc_write_data,
  input wire logic    check_word_cycle_flag,
  input wire logic    parity_cycle_flag,
  input wire logic    last_word_indicator,
  input wire logic    ready_req,
  input wire logic    protect_req,
  input wire logic    stall_req,
  output logic        disc_bit_clk,
  output sstel_disc_in_s disc_in,
  output logic [15:0] cap_check,
  output logic        cap_parity,
  output int          n_last,
  output int          n_gap,
  output int          n_check
);
  int   clk_cnt;
  logic sync_r;
  logic lw_q = 1'b0;
  logic ck_q = 1'b0;

  // Pins toward the formatter; protect follows protect_req
  assign disc_in = {ready_req, protect_req, sync_r, 1'b1};

  // Bit clock runs only while a transfer line is held
  initial begin
    disc_bit_clk = 1'b0;
    #7;
    forever begin
      if (write_line || read_line) begin
        #16 disc_bit_clk = 1'b1;
        #16 disc_bit_clk = 1'b0;
      end else
        #1;
    end
  end

  // A subsector opens after each restart pulse unless stalled
  initial begin
    sync_r = 1'b0;
    forever begin
      @(negedge (write_sector_go || read_sector_go));
      if (!stall_req) begin
        #40 sync_r = 1'b1;
        #100 sync_r = 1'b0;
      end
    end
  end

  // Count bit clocks from the start of each transfer
  always @(posedge (write_line || read_line)) clk_cnt = 0;
  always @(posedge disc_bit_clk) clk_cnt = clk_cnt + 1;

  // Record the trailer as the disc would see it
  always @(negedge disc_bit_clk) begin
    if (last_word_indicator && !lw_q) n_last = clk_cnt;
    if (check_word_cycle_flag && !ck_q) begin
      n_gap = clk_cnt - n_last;
      n_check = 0;
    end
    if (check_word_cycle_flag) begin
      cap_check = {cap_check[14:0], disc_write_data};
      n_check = n_check + 1;
    end
    if (parity_cycle_flag) cap_parity = disc_write_data;
    lw_q = last_word_indicator;
    ck_q = check_word_cycle_flag;
  end
endmodule : sstel_disc_model

// [tb/tb_top.sv]
// Self-checking bench: write, read, protect, drive loss, hang, status copy
`timescale 1ns/10ps
module tb_top;
  import sstel_pkg::*;
  logic core_clk, rst, disc_bit_clk, start_write, start_read, end_indicator, buffer_empty;
  logic end_of_read, interrupt_disable_flag, transfer_timing_error, illegal_address_error;
  logic read_error, data_bit, parity_bit, write_line, read_line, write_sector_go;
  logic read_sector_go, end_of_subsector_strobe, selected_busy, done, interrupt_request;
  logic last_word_indicator, check_word_cycle_flag, parity_cycle_flag, disc_write_data;
  logic data_suppress, ready_req, protect_req, stall_req, cap_parity;
  logic [15:0] check_word, cap_check;
  sstel_disc_in_s disc_in;
  sstel_status_s error_status;
  int n_mismatch, n_compared, n_strobe, n_irq, n_last, n_gap, n_check;

  sstel_trailer dut (.core_clk(core_clk), .rst(rst), .disc_bit_clk(disc_bit_clk),
    .start_write(start_write), .start_read(start_read), .end_indicator(end_indicator),
    .buffer_empty(buffer_empty), .end_of_read(end_of_read), .read_error(read_error),
    .interrupt_disable_flag(interrupt_disable_flag), .disc_in(disc_in),
    .transfer_timing_error(transfer_timing_error), .data_bit(data_bit),
    .illegal_address_error(illegal_address_error), .check_word(check_word),
    .parity_bit(parity_bit), .write_line(write_line), .read_line(read_line),
    .write_sector_go(write_sector_go), .read_sector_go(read_sector_go),
    .end_of_subsector_strobe(end_of_subsector_strobe), .selected_busy(selected_busy),
    .done(done), .interrupt_request(interrupt_request), .error_status(error_status),
    .last_word_indicator(last_word_indicator), .check_word_cycle_flag(check_word_cycle_flag),
    .parity_cycle_flag(parity_cycle_flag), .disc_write_data(disc_write_data),
    .data_suppress(data_suppress));

  sstel_disc_model u_disc (.write_line(write_line), .read_line(read_line),
    .write_sector_go(write_sector_go), .read_sector_go(read_sector_go),
    .disc_write_data(disc_write_data), .check_word_cycle_flag(check_word_cycle_flag),
    .parity_cycle_flag(parity_cycle_flag), .last_word_indicator(last_word_indicator),
    .ready_req(ready_req), .protect_req(protect_req), .stall_req(stall_req),
    .disc_bit_clk(disc_bit_clk), .disc_in(disc_in), .cap_check(cap_check),
    .cap_parity(cap_parity), .n_last(n_last), .n_gap(n_gap), .n_check(n_check));

  // Core clock, 20 ns period
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // Count end strobes and interrupt pulses
  always @(posedge core_clk) begin
    if (end_of_subsector_strobe === 1'b1) n_strobe++;
    if (interrupt_request === 1'b1) n_irq++;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t ns: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic start_op(input logic wr);
    n_strobe = 0;
    n_irq = 0;
    @(negedge core_clk);
    {start_write, start_read} = {wr, !wr};
    @(negedge core_clk);
    {start_write, start_read} = 2'b00;
  endtask : start_op

  task automatic wait_strobes(input int n);
    for (int i = 0; i < 3000 && n_strobe < n; i++) @(negedge core_clk);
    check(16'(n_strobe >= n), 16'h1, "strobe wait");
  endtask : wait_strobes

  task automatic wait_done;
    for (int i = 0; i < 3000 && done !== 1'b1; i++) @(negedge core_clk);
    check(done, 1'b1, "operation end");
    @(negedge core_clk);
  endtask : wait_done

  task automatic wrap_up;
    $display("compared %0d, mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // Watchdog: the full run needs well under 100 us
  initial begin
    #400000;
    n_mismatch++;
    $display("wrong value at %0t ns: run hung", $time);
    wrap_up;
  end

  // Test sequence
  initial begin
    {start_write, start_read, end_indicator, buffer_empty, end_of_read} = 5'h00;
    {interrupt_disable_flag, transfer_timing_error, illegal_address_error} = 3'h0;
    {read_error, protect_req, stall_req, parity_bit} = 4'h0;
    {ready_req, data_bit} = 2'b11;
    check_word = 16'h5a3c;
    {n_mismatch, n_compared} = 0;
    rst = 1'b1;
    repeat (2) @(negedge core_clk);
    rst = 1'b0;
    check(error_status, ERR_STATUS_RESET, "status after reset");
    ready_req = 1'b0;
    repeat (8) @(negedge core_clk);
    ready_req = 1'b1;
    repeat (8) @(negedge core_clk);
    check(error_status, 16'h0000, "idle drive loss");
    $display("test idle done");
    start_op(1'b1);
    wait_strobes(1);
    {end_indicator, buffer_empty} = 2'b11;
    wait_done;
    check(16'(n_strobe), 16'h2, "write subsectors");
    check(cap_check, check_word, "check word sent");
    check(cap_parity, parity_bit, "parity bit sent");
    check(16'(n_check), 16'h10, "check word length");
    check(16'(n_gap), 16'h10, "last word to check");
    check(16'(n_last >= 240 && n_last <= 245), 16'h1, "write last word");
    check({write_line, selected_busy}, 2'b00, "write ended");
    check(16'(n_irq), 16'h1, "end interrupt");
    $display("test write done");
    {protect_req, interrupt_disable_flag} = 2'b11;
    start_op(1'b1);
    wait_done;
    check(error_status, 16'h8800, "protect error");
    check(16'(n_irq), 16'h0, "masked interrupt");
    {protect_req, interrupt_disable_flag} = 2'b00;
    $display("test protect done");
    start_op(1'b1);
    for (int i = 0; i < 200 && write_line !== 1'b1; i++) @(negedge core_clk);
    repeat (50) @(negedge core_clk);
    ready_req = 1'b0;
    wait_done;
    check(error_status, 16'h8400, "drive loss");
    check(selected_busy, 1'b0, "busy dropped");
    ready_req = 1'b1;
    $display("test drive loss done");
    start_op(1'b0);
    wait_strobes(1);
    end_of_read = 1'b1;
    wait_done;
    check(16'(n_strobe), 16'h2, "read subsectors");
    check(16'(n_last >= 241 && n_last <= 246), 16'h1, "read last word");
    check(read_line, 1'b0, "read ended");
    check(error_status, 16'h0000, "flags cleared");
    $display("test read done");
    stall_req = 1'b1;
    start_op(1'b1);
    wait_done;
    check(error_status, 16'h8400, "hang timeout");
    stall_req = 1'b0;
    $display("test hang done");
    {transfer_timing_error, illegal_address_error, read_error} = 3'b111;
    repeat (4) @(negedge core_clk);
    check(error_status, 16'hf400, "all error bits");
    $display("test status done");
    wrap_up;
  end
endmodule : tb_top
